// [verilog/icp_timer.sv]
// Top level: 8-bit PWM / infrared carrier timer with Avalon-MM registers
//
// Contract
// R1 - Run enable starts counter, masks first count clock, output stays default.
// R2 - PWM period match clears counter, inverts output, pulses match interrupt.
// R3 - PWM duty match inverts output only; no clear, no interrupt.
// R4 - Duty writes while counting are latched, applied at old duty match.
// R5 - Latched duty applies only after three count clocks since the write.
// R6 - Clearing run enable returns interrupt and output to default levels.
// R7 - Carrier: period sets low width, duty sets high width; duty rewritable.
// R8 - Carrier compares period first; each match interrupts, clears, swaps.
// R9 - Carrier clock inverts on each match, starts at default level.
// R10 - Carrier cycle N+M+2 count clocks, high share M+1.
// R11 - Pin: 00 low, 01 high, 10 low, 11 carrier pulse.
// R12 - Gate is a writable buffer bit and a read-only active bit.
// R13 - Interval event is synchronised to the count clock as transfer strobe.
// R14 - Buffer copied into active bit two count clocks after synced rise.
// R15 - Software spaces buffer gate writes by at least two clocks.
// R16 - Software reloads buffer gate from synced event handler or polling.
// R17 - Pin carries carrier while active bit high, low when it is zero; code starts at a carrier rise and finishes a started high phase first.
// R18 - Software rewrites duty compare on every restart.
// R19 - Software keeps count clock above six times interval counter clock.
// R20 - Carrier compare values stay within 01h to ffh.
// R21 - Software sets remote output enable before starting the counter.
// R22 - PWM period N+1 count clocks, duty share M+1.
// R23 - PWM duty compare strictly below period compare.
// R24 - Counter and compare logic hold still while run enable is clear.
`timescale 1ns/1ns
module icp_timer
  import icp_pkg::*;
#(
  parameter int MAX_SEL = 7
)
(
  input wire logic clk, // System clock, 100 MHz
  input wire logic resetn, // Asynchronous reset, active low
  input wire logic [4:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Slave not ready
  input wire logic interval_counter_event, // Event from interval counter, async
  output logic timer_output_pin, // Timer output toward the transmitter
  output logic match_interrupt, // One-cycle pulse per period match, and per duty match in carrier mode
  output logic synced_interval_event // Interval event on count clock, one period
);
  // Bus registers
  logic run_q;
  logic mode_q;
  logic [ICP_CKS_W-1:0] cks_q;
  logic [7:0] period_q;
  logic [7:0] duty_latch_q;
  logic [7:0] duty_act_q;
  logic duty_pend_q;
  logic [1:0] duty_age_q;
  logic gate_buf_q;
  logic gate_act_q;
  logic rmc_q;
  // Timer core
  logic run_prev_q;
  logic mask_q;
  logic [7:0] count_q;
  logic [7:0] count_d;
  icp_sel_type sel_q;
  logic out_q;
  logic carrier_q;
  logic carrier_prev_q;
  logic carrier_on_q;
  // Interval event path
  logic ev_sync;
  logic ev_prev_q;
  logic ev_pend_q;
  logic xfer1_q;
  logic xfer2_q;
  logic tick;

  // Bus decode
  logic bus_req;
  logic wr_go;
  logic lane0;
  logic wr_ctrl;
  logic wr_period;
  logic wr_duty;
  logic wr_car;
  logic [31:0] rd_mux;

  function automatic logic hit_addr(input logic [4:0] addr, input logic [4:0] ofs);
    hit_addr = (addr[4:2] == ofs[4:2]);
  endfunction
  assign bus_req = avs_read | avs_write;
  // Write takes effect only at the edge where waitrequest is seen low
  assign wr_go = avs_write & ~avs_waitrequest;
  assign lane0 = avs_byteenable[0];
  assign wr_ctrl = wr_go & lane0 & hit_addr(avs_address, ICP_OFS_CTRL);
  assign wr_period = wr_go & lane0 & hit_addr(avs_address, ICP_OFS_PERIOD);
  assign wr_duty = wr_go & lane0 & hit_addr(avs_address, ICP_OFS_DUTY);
  assign wr_car = wr_go & lane0 & hit_addr(avs_address, ICP_OFS_CARRIER);
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (hit_addr(avs_address, ICP_OFS_CTRL))
    begin
      rd_mux[ICP_CTRL_RUN_BIT] = run_q;
      rd_mux[ICP_CTRL_MODE_BIT] = mode_q;
      rd_mux[ICP_CTRL_CKS_LSB +: ICP_CKS_W] = cks_q;
    end
    else if (hit_addr(avs_address, ICP_OFS_PERIOD))
      rd_mux[7:0] = period_q;
    else if (hit_addr(avs_address, ICP_OFS_DUTY))
      rd_mux[7:0] = duty_latch_q;
    else if (hit_addr(avs_address, ICP_OFS_CARRIER))
    begin
      rd_mux[ICP_CAR_ACTIVE_BIT] = gate_act_q;
      rd_mux[ICP_CAR_BUFFER_BIT] = gate_buf_q;
      rd_mux[ICP_CAR_RMC_BIT] = rmc_q;
    end
    else if (hit_addr(avs_address, ICP_OFS_STATUS))
    begin
      rd_mux[ICP_ST_COUNT_LSB +: 8] = count_q;
      rd_mux[ICP_ST_PIN_BIT] = timer_output_pin;
      rd_mux[ICP_ST_SEL_BIT] = sel_q;
      rd_mux[ICP_ST_PEND_BIT] = duty_pend_q;
      rd_mux[ICP_ST_DUTY_LSB +: 8] = duty_act_q;
    end
  end
  // One wait cycle, then a one-cycle acknowledge
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end
    else if (bus_req & avs_waitrequest)
    begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= rd_mux;
    end
    else
      avs_waitrequest <= 1'b1;
  end

  // Software-written control bits
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      run_q <= 1'b0;
      mode_q <= ICP_MODE_PWM;
      cks_q <= '0;
      period_q <= ICP_RST_PERIOD;
      gate_buf_q <= 1'b0;
      rmc_q <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        run_q <= avs_writedata[ICP_CTRL_RUN_BIT];
        mode_q <= avs_writedata[ICP_CTRL_MODE_BIT];
        cks_q <= avs_writedata[ICP_CTRL_CKS_LSB +: ICP_CKS_W];
      end
      if (wr_period)
        period_q <= avs_writedata[7:0];
      // R12 buffer gate bit
      if (wr_car)
      begin
        gate_buf_q <= avs_writedata[ICP_CAR_BUFFER_BIT];
        rmc_q <= avs_writedata[ICP_CAR_RMC_BIT];
      end
    end
  end
  icp_prescaler #(
    .MAX_SEL(MAX_SEL)
  ) u_prescaler (
    .clk(clk),
    .resetn(resetn),
    .enable(run_q),
    .select(cks_q),
    .tick(tick)
  );
  // Compare and match
  logic start;
  logic counting;
  logic [7:0] cmp_val;
  logic hit;
  logic hit_period;
  logic hit_duty;
  logic clear_cnt;
  logic duty_take;
  assign start = run_q & ~run_prev_q;
  assign counting = run_q & tick & ~mask_q;
  // R7 R8 period compared first, then duty
  assign cmp_val = (sel_q == ICP_SEL_DUTY) ? duty_act_q : period_q;
  assign hit = counting & (count_q == cmp_val);
  assign hit_period = hit & (sel_q == ICP_SEL_PERIOD);
  assign hit_duty = hit & (sel_q == ICP_SEL_DUTY);
  // R2 R8 clear on period match, and on duty match in carrier mode
  assign clear_cnt = hit_period | (hit_duty & (mode_q == ICP_MODE_CARRIER));
  assign count_d = clear_cnt ? ICP_RST_COUNT : count_q + 8'h01;
  // R4 R5 latched duty taken at old-duty match once settled
  assign duty_take = hit_duty & duty_pend_q & (duty_age_q >= ICP_DUTY_SETTLE_TICKS);

  // Counter, compare select and PWM level
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mask_q <= 1'b0;
      count_q <= ICP_RST_COUNT;
      sel_q <= ICP_SEL_PERIOD;
      out_q <= 1'b0;
      carrier_q <= 1'b0;
    end
    else if (!run_q)
    begin
      // R6 R24 stop: levels default, count and select held
      out_q <= 1'b0;
      carrier_q <= 1'b0;
    end
    else if (start)
    begin
      // R1 R9 first count clock masked, levels at default
      mask_q <= 1'b1;
      count_q <= ICP_RST_COUNT;
      sel_q <= ICP_SEL_PERIOD;
      out_q <= 1'b0;
      carrier_q <= 1'b0;
    end
    else if (tick & mask_q)
      mask_q <= 1'b0;
    else if (counting)
    begin
      // R22 R10 counter runs 0..N, then 0..M in carrier mode
      count_q <= count_d;
      if (hit)
      begin
        // R3 R8 swap compare register on each match
        sel_q <= (sel_q == ICP_SEL_PERIOD) ? ICP_SEL_DUTY : ICP_SEL_PERIOD;
        // R2 R3 PWM inverts on both matches
        if (mode_q == ICP_MODE_PWM)
          out_q <= ~out_q;
        // R9 carrier clock toggles on every match
        else
          carrier_q <= ~carrier_q;
      end
    end
  end

  // Duty compare: latch, age and transfer
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      duty_latch_q <= ICP_RST_DUTY;
      duty_act_q <= ICP_RST_DUTY;
      duty_pend_q <= 1'b0;
      duty_age_q <= 2'h0;
    end
    else if (wr_duty)
    begin
      // R4 new write wins over a transfer; a stopped timer takes it at once
      duty_latch_q <= avs_writedata[7:0];
      duty_pend_q <= run_q;
      duty_age_q <= 2'h0;
      if (!run_q)
        duty_act_q <= avs_writedata[7:0];
    end
    else
    begin
      // R5 count settle time in count clocks
      if (duty_pend_q & tick & (duty_age_q < ICP_DUTY_SETTLE_TICKS))
        duty_age_q <= duty_age_q + 2'h1;
      // R4 transfer on match with the old value
      if (duty_take)
      begin
        duty_act_q <= duty_latch_q;
        duty_pend_q <= 1'b0;
      end
    end
  end

  // Interval event path
  icp_sync #(
    .WIDTH(1)
  ) u_ev_sync (
    .clk(clk),
    .resetn(resetn),
    .d_async(interval_counter_event),
    .q(ev_sync)
  );
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ev_prev_q <= 1'b0;
      ev_pend_q <= 1'b0;
      synced_interval_event <= 1'b0;
      xfer1_q <= 1'b0;
      xfer2_q <= 1'b0;
      gate_act_q <= 1'b0;
    end
    else
    begin
      ev_prev_q <= ev_sync;
      // Event held until the next count clock so none is lost
      if (ev_sync & ~ev_prev_q)
        ev_pend_q <= 1'b1;
      else if (tick)
        ev_pend_q <= 1'b0;
      if (tick)
      begin
        // R13 event re-timed onto the count clock
        synced_interval_event <= ev_pend_q;
        xfer1_q <= ev_pend_q;
        xfer2_q <= xfer1_q;
        // R14 copy buffer to active at second count clock
        if (xfer2_q)
          gate_act_q <= gate_buf_q;
      end
    end
  end

  // Carrier gating holds a started high phase until it ends
  logic carrier_pin;
  logic pin_d;
  logic carrier_start;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      run_prev_q <= 1'b0;
      carrier_prev_q <= 1'b0;
      carrier_on_q <= 1'b0;
    end
    else
    begin
      run_prev_q <= run_q;
      carrier_prev_q <= carrier_q;
      // R17 start at first carrier rise, stop only once carrier is low
      if (carrier_start)
        carrier_on_q <= 1'b1;
      else if (~gate_act_q & ~carrier_q)
        carrier_on_q <= 1'b0;
    end
  end
  // R11 R10 first rise passes at once so its high phase keeps full width
  assign carrier_start = gate_act_q & carrier_q & ~carrier_prev_q;
  assign carrier_pin = rmc_q ? (carrier_q & (carrier_on_q | carrier_start)) : gate_act_q;
  assign pin_d = (mode_q == ICP_MODE_CARRIER) ? carrier_pin : out_q;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      timer_output_pin <= 1'b0;
      match_interrupt <= 1'b0;
    end
    else
    begin
      // R6 default levels while stopped
      timer_output_pin <= run_q & pin_d;
      // R2 R3 R8 interrupt on period match, and on duty match in carrier mode
      match_interrupt <= run_q & clear_cnt;
    end
  end
endmodule // icp_timer

// [include/icp_pkg.sv]
// Shared constants and types for the infrared carrier / PWM timer
package icp_pkg;
  // Register byte offsets on the Avalon-MM slave
  localparam logic [4:0] ICP_OFS_CTRL = 5'h00;
  localparam logic [4:0] ICP_OFS_PERIOD = 5'h04;
  localparam logic [4:0] ICP_OFS_DUTY = 5'h08;
  localparam logic [4:0] ICP_OFS_CARRIER = 5'h0c;
  localparam logic [4:0] ICP_OFS_STATUS = 5'h10;

  // Mode register fields
  localparam int ICP_CTRL_RUN_BIT = 0;
  localparam int ICP_CTRL_MODE_BIT = 1;
  localparam int ICP_CTRL_CKS_LSB = 2;
  localparam int ICP_CKS_W = 3;

  // Carrier control register fields
  localparam int ICP_CAR_ACTIVE_BIT = 0;
  localparam int ICP_CAR_BUFFER_BIT = 1;
  localparam int ICP_CAR_RMC_BIT = 2;

  // Status register fields
  localparam int ICP_ST_COUNT_LSB = 0;
  localparam int ICP_ST_PIN_BIT = 8;
  localparam int ICP_ST_SEL_BIT = 9;
  localparam int ICP_ST_PEND_BIT = 10;
  localparam int ICP_ST_DUTY_LSB = 16;

  // Reset values
  localparam logic [7:0] ICP_RST_PERIOD = 8'h00;
  localparam logic [7:0] ICP_RST_DUTY = 8'h00;
  localparam logic [7:0] ICP_RST_COUNT = 8'h00;

  // Count clocks a new duty value must wait before it may be taken over
  localparam logic [1:0] ICP_DUTY_SETTLE_TICKS = 2'h3;

  // Timer mode
  typedef enum logic
  {
    ICP_MODE_PWM = 1'b0,
    ICP_MODE_CARRIER = 1'b1
  } icp_mode_type;

  // Compare register currently watched
  typedef enum logic
  {
    ICP_SEL_PERIOD = 1'b0,
    ICP_SEL_DUTY = 1'b1
  } icp_sel_type;
endpackage

// [verilog/icp_sync.sv]
// Two flip-flop synchroniser for asynchronous inputs
`timescale 1ns/1ns
module icp_sync
  import icp_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input wire logic clk, // System clock
  input wire logic resetn, // Asynchronous reset, active low
  input wire logic [WIDTH-1:0] d_async, // Input from another domain
  output logic [WIDTH-1:0] q // Synchronised level
);
  logic [WIDTH-1:0] meta_q;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
        begin
          meta_q[i] <= 1'b0;
          q[i] <= 1'b0;
        end
        else
        begin
          meta_q[i] <= d_async[i];
          q[i] <= meta_q[i];
        end
      end
    end
  endgenerate
endmodule // icp_sync

// [verilog/icp_prescaler.sv]
// Count clock prescaler: one-cycle tick every 2**select system clocks
`timescale 1ns/1ns
module icp_prescaler
  import icp_pkg::*;
#(
  parameter int MAX_SEL = 7
)
(
  input wire logic clk, // System clock
  input wire logic resetn, // Asynchronous reset, active low
  input wire logic enable, // Prescaler runs while high
  input wire logic [ICP_CKS_W-1:0] select, // Divide by 2**select
  output logic tick // Count clock enable pulse
);
  logic [MAX_SEL-1:0] div_q;
  logic [MAX_SEL-1:0] div_d;
  logic [MAX_SEL-1:0] limit;
  logic wrap;

  assign limit = MAX_SEL'((1 << select) - 1);
  assign wrap = (div_q >= limit);
  assign div_d = wrap ? '0 : div_q + MAX_SEL'(1);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      div_q <= '0;
      tick <= 1'b0;
    end
    else if (!enable)
    begin
      // Restart phase so the first count clock is a full period
      div_q <= '0;
      tick <= 1'b0;
    end
    else
    begin
      div_q <= div_d;
      tick <= wrap;
    end
  end
endmodule // icp_prescaler

// [bench/icp_timer_monitor.sv]
// Port checker for the PWM / carrier timer
`timescale 1ns/1ns
module icp_timer_monitor
  import icp_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic resetn, // Reset, active low
  input wire logic [4:0] avs_address, // Byte address
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  input wire logic avs_waitrequest, // Slave not ready
  input wire logic interval_counter_event, // Async interval event
  input wire logic timer_output_pin, // Timer output
  input wire logic match_interrupt, // Match pulse
  input wire logic synced_interval_event // Synced event
);
  logic run_q, mode_q, rmc_q, seen_q;
  logic [2:0] sel_q;
  logic [1:0] stop_q;
  logic [7:0] period_q;
  logic [15:0] gap_q;
  wire wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire [2:0] word = avs_address[4:2];
  // Mirror of the control fields, taken at the accepting edge
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      {run_q, mode_q, sel_q, rmc_q, period_q} <= '0;
    else if (wr_ok)
    begin
      if (word == ICP_OFS_CTRL[4:2])
        {sel_q, mode_q, run_q} <= avs_writedata[4:0];
      if (word == ICP_OFS_PERIOD[4:2])
        period_q <= avs_writedata[7:0];
      if (word == ICP_OFS_CARRIER[4:2])
        rmc_q <= avs_writedata[ICP_CAR_RMC_BIT];
    end
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      stop_q <= '0;
      gap_q <= '0;
      seen_q <= 1'b0;
    end
    else
    begin
      stop_q <= run_q ? 2'h0 : (stop_q == 2'h3 ? stop_q : stop_q + 2'h1);
      gap_q <= match_interrupt ? 16'h0001 : gap_q + 16'h0001;
      seen_q <= run_q && (seen_q || match_interrupt);
    end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  sequence s_pwm_start;
    $rose(run_q) && !mode_q;
  endsequence
  a_start_default: assert property (
    s_pwm_start |-> !timer_output_pin [*2]) else $error("pin moved at start");
  a_period_rise: assert property (
    match_interrupt && run_q && !mode_q |=> timer_output_pin && !$past(timer_output_pin))
    else $error("period match without pin rise");
  a_duty_quiet: assert property (
    run_q && !mode_q && $fell(timer_output_pin) |-> !$past(match_interrupt))
    else $error("interrupt on duty match");
  a_stop_default: assert property (
    stop_q >= 2'h2 |-> !timer_output_pin && !match_interrupt)
    else $error("outputs active while stopped");
  a_pwm_period: assert property (
    match_interrupt && seen_q && !mode_q |-> gap_q == (({8'h00, period_q} + 16'h0001) << sel_q))
    else $error("PWM period length wrong");
  a_carrier_edge: assert property (
    run_q && $past(run_q) && mode_q && rmc_q && $changed(timer_output_pin) |-> $past(match_interrupt))
    else $error("carrier edge without match");
  a_sync_bound: assert property (
    $rose(interval_counter_event) && run_q && sel_q == 3'h0 |-> ##[2:8] synced_interval_event)
    else $error("synced event missing");
  a_irq_single: assert property (
    match_interrupt |=> !match_interrupt) else $error("interrupt longer than one cycle");
endmodule // icp_timer_monitor

bind icp_timer icp_timer_monitor u_mon (
  .clk(clk),
  .resetn(resetn),
  .avs_address(avs_address),
  .avs_write(avs_write),
  .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable),
  .avs_waitrequest(avs_waitrequest),
  .interval_counter_event(interval_counter_event),
  .timer_output_pin(timer_output_pin),
  .match_interrupt(match_interrupt),
  .synced_interval_event(synced_interval_event)
);

// [bench/icp_ir_partner.sv]
// Infrared transmitter model that measures the drive waveform
`timescale 1ns/1ns
module icp_ir_partner
(
  input wire logic clk, // System clock
  input wire logic resetn, // Reset, active low
  input wire logic ir_drive, // Level at the emitter driver
  output logic [15:0] hi_width, // Last finished high run, clocks
  output logic [15:0] lo_width, // Last finished low run, clocks
  output logic [15:0] rises // Rising edges seen
);
  logic prev_q;
  logic [15:0] len_q;
  // Emitter only listens; it never loads the pin
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      {prev_q, len_q, hi_width, lo_width, rises} <= '0;
    end
    else
    begin
      prev_q <= ir_drive;
      len_q <= (ir_drive != prev_q) ? 16'h0001 : len_q + 16'h0001;
      if (ir_drive != prev_q && prev_q)
        hi_width <= len_q;
      if (ir_drive != prev_q && !prev_q)
        lo_width <= len_q;
      if (ir_drive && !prev_q)
        rises <= rises + 16'h0001;
    end
endmodule // icp_ir_partner

// [bench/icp_timer_tb.sv]
// Self-checking bench for the PWM / carrier timer
`timescale 1ns/1ns
module icp_timer_tb
  import icp_pkg::*;
;
  // carrier values within 01h..ffh, PWM duty below period
  localparam logic [7:0] NP = 8'h04, MP = 8'h01, MQ = 8'h02, NC = 8'h03, MC = 8'h01;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, timer_output_pin, match_interrupt, synced_interval_event;
  logic interval_counter_event = 1'b0;
  logic [15:0] hi_width, lo_width, rises, r0;
  int failures = 0;
  int checked = 0;
  always #5 clk = ~clk;
  icp_timer u_dut (
    .clk(clk),
    .resetn(resetn),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(4'h1),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .interval_counter_event(interval_counter_event),
    .timer_output_pin(timer_output_pin),
    .match_interrupt(match_interrupt),
    .synced_interval_event(synced_interval_event)
  );
  icp_ir_partner u_ir (
    .clk(clk),
    .resetn(resetn),
    .ir_drive(timer_output_pin),
    .hi_width(hi_width),
    .lo_width(lo_width),
    .rises(rises)
  );
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One transfer; an extra edge lets the release land
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    check(avs_waitrequest, 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge clk);
    failures++;
    close_out();
  end
  initial
  begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    bus(1'b1, 5'h14, 32'hff);
    for (int w = 0; w < 8; w++)
    begin
      bus(1'b0, {3'(w), 2'b00}, 32'h0);
      check(rd, 32'h0);
    end
    bus(1'b1, ICP_OFS_PERIOD, {24'h0, NP});
    bus(1'b1, ICP_OFS_DUTY, {24'h0, MP});
    bus(1'b1, ICP_OFS_CTRL, 32'h5);
    repeat (60) @(posedge clk);
    check(hi_width, 32'((MP + 1) << 1));
    check(lo_width, 32'((NP - MP) << 1));
    // Duty change while running is parked first
    bus(1'b1, ICP_OFS_DUTY, {24'h0, MQ});
    bus(1'b0, ICP_OFS_STATUS, 32'h0);
    check(rd[23:16], MP);
    check(rd[ICP_ST_PEND_BIT], 1'b1);
    repeat (60) @(posedge clk);
    check(hi_width, 32'((MQ + 1) << 1));
    bus(1'b1, ICP_OFS_CTRL, 32'h4);
    bus(1'b0, ICP_OFS_STATUS, 32'h0);
    r0 = rd[15:0];
    check(rd[ICP_ST_PIN_BIT], 1'b0);
    repeat (20) @(posedge clk);
    bus(1'b0, ICP_OFS_STATUS, 32'h0);
    check(rd[15:0], r0);
    bus(1'b1, ICP_OFS_PERIOD, {24'h0, NC});
    bus(1'b1, ICP_OFS_CARRIER, 32'h7);
    bus(1'b0, ICP_OFS_CARRIER, 32'h0);
    check(rd, 32'h6);
    for (int k = 0; k < 4; k++)
    begin
      bus(1'b1, ICP_OFS_CTRL, 32'h0);
      // gate bits loaded once, while stopped
      bus(1'b1, ICP_OFS_CARRIER, {29'h0, k[1], k[0], 1'b0});
      bus(1'b1, ICP_OFS_DUTY, {24'h0, MC});
      bus(1'b1, ICP_OFS_CTRL, 32'h3);
      // one slow event per run, far below the count clock
      interval_counter_event <= 1'b1;
      repeat (3) @(posedge clk);
      interval_counter_event <= 1'b0;
      repeat (40) @(posedge clk);
      bus(1'b0, ICP_OFS_CARRIER, 32'h0);
      check(rd[ICP_CAR_ACTIVE_BIT], k[0]);
      r0 = rises;
      repeat (40) @(posedge clk);
      if (k == 3)
      begin
        check(hi_width, 32'(MC + 1));
        check(lo_width, 32'(NC + 1));
      end
      else
      begin
        check(rises, r0);
        check(timer_output_pin, k == 1);
      end
    end
    close_out();
  end
endmodule // icp_timer_tb
